/* File: design/hpr_defs.svh */
`ifndef HPR_DEFS_SVH
`define HPR_DEFS_SVH
// ****************************************
// Register addresses (full 23-bit address)
// ****************************************
`define HPR_A_CFG 23'h000000
`define HPR_A_MON 23'h000057
`define HPR_A_SRST 23'h00007f
`define HPR_A_CNT0 23'h000084
`define HPR_A_CNT1 23'h000085
// ****************************************
// Field positions and codes
// ****************************************
`define HPR_CFG_CUT 5
`define HPR_CNT1_REQ 8
`define HPR_C_PULSE 16'had00
`define HPR_C_HOLD 16'haa00
`define HPR_C_REL 16'hdd00
`define HPR_MON_RST 16'h0000
`define HPR_CNT_MAX 8'hff
`define HPR_CLR_IDLE 2'h0
`define HPR_CLR_DONE 2'h2
`define HPR_PIN_RST 3'h6
// ****************************************
// Timing
// ****************************************
`define HPR_CLK_NS 10
`define HPR_RECOV_NS 5000000
`define HPR_RECOV_CYC (`HPR_RECOV_NS / `HPR_CLK_NS)
`endif

/* File: design/hpr_pkg.sv */
package hpr_pkg;
    // Serial word phases
    typedef enum logic [1:0] {
        ST_CW1 = 2'b00,
        ST_CW2 = 2'b01,
        ST_DATA = 2'b10,
        ST_SKIP = 2'b11
    } hpr_st_t;
    // First command word layout
    typedef struct packed {
        logic rd;
        logic bcast;
        logic step;
        logic rsv;
        logic [4:0] unit;
        logic [6:0] hi;
    } hpr_cw_t;
    // Monitored link status
    typedef struct packed {
        logic carrier;
        logic [2:0] rate;
        logic lock;
    } hpr_stat_t;
endpackage

/* File: design/hpr_top.sv */
`timescale 1ns/1ps
`include "hpr_defs.svh"
// How it works
// - Reset: pass-through on, unit identifier zero
// - Autostep applies data to consecutive registers
// - Accept only matching unit identifier or broadcast
// - Three change counters at 0x84, 0x85
// - Counters saturate at 255 until cleared
// - Clear request zeroes counters, state two
// - Request dropped returns state to idle
// - No host access during boot
// - Code AD00 pulses reset then recovers
// - AA00 holds reset, DD00 releases
// - Reset register reads AA00 while reset is held, else zero
// - In reset only reset register acts
// - Logic leaves reset 5ms after release
// - Reset via 0xAD00 to 0x007F, broadcast allowed
// - Autostep bit; advance until select rises
// - Reset register at 7F, read/write
module hpr_top
    import hpr_pkg::*;
#(
    parameter int unsigned RECOV_CYC = `HPR_RECOV_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdin,
    input wire hpr_stat_t stat,
    output logic sdout,
    output logic logic_rst,
    output logic cut,
    output logic [15:0] mon_cfg
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pins;
    logic [2:0] s1, s2, s3, flt, next_flt;
    logic rise, fall, desel;

    assign pins = {sclk, cs_n, sdin};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            // Level moves only once stages two and three agree
            always_comb begin
                next_flt[g] = (s2[g] == s3[g]) ? s3[g] : flt[g];
            end
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    s1[g] <= 1'(`HPR_PIN_RST >> g); // Idle level, no edge
                    s2[g] <= 1'(`HPR_PIN_RST >> g);
                    s3[g] <= 1'(`HPR_PIN_RST >> g);
                    flt[g] <= 1'(`HPR_PIN_RST >> g);
                end else if (ce) begin
                    s1[g] <= pins[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    flt[g] <= next_flt[g];
                end
            end
        end
    endgenerate

    // Edges seen on the filtered serial clock
    assign rise = next_flt[2] & ~flt[2];
    assign fall = ~next_flt[2] & flt[2];
    assign desel = next_flt[1];

    // ****************************************
    // Serial port engine and registers
    // ****************************************
    hpr_st_t st, next_st;
    hpr_cw_t cw, next_cw;
    logic [3:0] cnt, next_cnt;
    logic [15:0] sh, next_sh, osh, next_osh, w, rv;
    logic [22:0] addr, next_addr, ra;
    logic [4:0] unit, next_unit;
    logic next_cut, next_sdout, hold, next_hold;
    logic clr_req, next_clr_req, next_logic_rst, wr_en;
    logic [15:0] next_mon;
    logic [19:0] rcnt, next_rcnt;
    logic [1:0] clr_st;
    logic [7:0] cnt8 [3];

    // Unit match, broadcast reaches every unit
    function automatic logic hit(hpr_cw_t c, logic [4:0] u);
        hit = c.bcast | (c.unit == u);
    endfunction

    // Read word for the address about to be served
    always_comb begin
        ra = (st == ST_CW2) ? {cw.hi, w} : addr + 23'h1;
        case (ra)
            `HPR_A_CFG: rv = {10'h0, cut, unit};
            `HPR_A_MON: rv = mon_cfg;
            `HPR_A_SRST: rv = hold ? `HPR_C_HOLD : 16'h0000;
            `HPR_A_CNT0: rv = {cnt8[1], cnt8[0]};
            `HPR_A_CNT1: rv = {5'h0, clr_st, clr_req, cnt8[2]};
            default: rv = 16'h0000;
        endcase
        // Nothing but the reset register answers in reset
        if (logic_rst && ra != `HPR_A_SRST) begin
            rv = 16'h0000;
        end
    end

    // Word assembly, address stepping and register writes
    always_comb begin
        next_st = st;
        next_cw = cw;
        next_cnt = cnt;
        next_sh = sh;
        next_osh = osh;
        next_addr = addr;
        next_unit = unit;
        next_cut = cut;
        next_mon = mon_cfg;
        next_hold = hold;
        next_clr_req = clr_req;
        next_rcnt = rcnt;
        wr_en = 1'b0;
        w = {sh[14:0], next_flt[0]};
        // Recovery runs only once the hold is gone
        if (!hold && rcnt != 20'h0) begin
            next_rcnt = rcnt - 20'h1;
        end
        // Config stays at defaults while reset stands
        if (logic_rst) begin
            next_unit = 5'h0;
            next_cut = 1'b0;
            next_mon = `HPR_MON_RST;
            next_clr_req = 1'b0;
        end
        if (rise) begin
            next_sh = w;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'hf) begin
                case (st)
                    ST_CW1: begin
                        next_cw = w;
                        next_st = ST_CW2;
                    end
                    ST_CW2: begin
                        next_addr = {cw.hi, w};
                        next_st = hit(cw, unit) ? ST_DATA : ST_SKIP;
                        next_osh = rv;
                    end
                    ST_DATA: begin
                        wr_en = !cw.rd
                            && (!logic_rst || addr == `HPR_A_SRST);
                        if (cw.step) begin
                            next_addr = addr + 23'h1;
                            next_osh = rv;
                        end else begin
                            next_st = ST_SKIP;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (wr_en) begin
            case (addr)
                `HPR_A_CFG: begin
                    next_unit = w[4:0];
                    next_cut = w[`HPR_CFG_CUT];
                end
                `HPR_A_MON: next_mon = w;
                `HPR_A_CNT1: next_clr_req = w[`HPR_CNT1_REQ];
                `HPR_A_SRST: begin
                    if (w == `HPR_C_PULSE) begin
                        next_rcnt = 20'(RECOV_CYC);
                    end else if (w == `HPR_C_HOLD) begin
                        next_hold = 1'b1;
                    end else if (w == `HPR_C_REL && hold) begin
                        next_hold = 1'b0;
                        next_rcnt = 20'(RECOV_CYC);
                    end
                end
                default: ;
            endcase
        end
        // Read data leaves on the falling edge, else pass-through, or zero while cut is set
        if (st == ST_DATA && cw.rd) begin
            next_sdout = sdout;
            if (fall) begin
                next_sdout = osh[15];
                next_osh = {osh[14:0], 1'b0};
            end
        end else begin
            next_sdout = cut ? 1'b0 : next_flt[0];
        end
        // Select rising ends any transfer
        if (desel) begin
            next_st = ST_CW1;
            next_cnt = 4'h0;
        end
        next_logic_rst = next_hold | (next_rcnt != 20'h0);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_CW1;
            cw <= '0;
            cnt <= 4'h0;
            sh <= 16'h0;
            osh <= 16'h0;
            addr <= 23'h0;
            unit <= 5'h0;
            cut <= 1'b0;
            mon_cfg <= `HPR_MON_RST;
            hold <= 1'b0;
            clr_req <= 1'b0;
            rcnt <= 20'h0;
            sdout <= 1'b0;
            logic_rst <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            cw <= next_cw;
            cnt <= next_cnt;
            sh <= next_sh;
            osh <= next_osh;
            addr <= next_addr;
            unit <= next_unit;
            cut <= next_cut;
            mon_cfg <= next_mon;
            hold <= next_hold;
            clr_req <= next_clr_req;
            rcnt <= next_rcnt;
            sdout <= next_sdout;
            logic_rst <= next_logic_rst;
        end
    end

    // ****************************************
    // Sticky change counters
    // ****************************************
    hpr_stat_t prev, next_prev;
    logic [2:0] ev;
    logic [7:0] next_cnt8 [3];
    logic [1:0] next_clr_st;
    logic clr_go;

    // Change count and four-way clear handshake
    always_comb begin
        next_prev = stat;
        next_clr_st = clr_st;
        ev[0] = stat.carrier != prev.carrier;
        ev[1] = stat.rate != prev.rate;
        ev[2] = stat.lock != prev.lock;
        clr_go = clr_req && clr_st == `HPR_CLR_IDLE;
        if (clr_go) begin
            next_clr_st = `HPR_CLR_DONE;
        end else if (clr_st == `HPR_CLR_DONE && !clr_req) begin
            next_clr_st = `HPR_CLR_IDLE;
        end
        for (int i = 0; i < 3; i++) begin
            next_cnt8[i] = cnt8[i];
            // A change in the clear cycle still counts once
            if (clr_go) begin
                next_cnt8[i] = ev[i] ? 8'h01 : 8'h00;
            end else if (ev[i] && cnt8[i] != `HPR_CNT_MAX) begin
                next_cnt8[i] = cnt8[i] + 8'h01;
            end
        end
        if (logic_rst) begin
            next_clr_st = `HPR_CLR_IDLE;
            for (int i = 0; i < 3; i++) begin
                next_cnt8[i] = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev <= '0;
            clr_st <= `HPR_CLR_IDLE;
            for (int i = 0; i < 3; i++) begin
                cnt8[i] <= 8'h00;
            end
        end else if (ce) begin
            prev <= next_prev;
            clr_st <= next_clr_st;
            for (int i = 0; i < 3; i++) begin
                cnt8[i] <= next_cnt8[i];
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_unit_filter: assert property (
        (ce && rise && !desel && cnt == 4'hf && st == ST_CW2
            && !hit(cw, unit)) |=> st == ST_SKIP)
        else $error("foreign unit access accepted");
    a_addr_step: assert property (
        (ce && wr_en && cw.step && !desel)
            |=> addr == $past(addr) + 23'h1)
        else $error("autostep address did not advance");
    a_cnt_saturate: assert property (
        (ce && !logic_rst && !clr_go && cnt8[2] == 8'hff)
            |=> cnt8[2] == 8'hff)
        else $error("counter left saturation");
    a_cnt_step: assert property (
        (ce && !logic_rst && !clr_go && ev[2] && cnt8[2] != 8'hff)
            |=> cnt8[2] == $past(cnt8[2]) + 8'h01)
        else $error("counter did not step by one");
    a_clear_zero: assert property (
        (ce && clr_go && !logic_rst && !ev[1])
            |=> cnt8[1] == 8'h00 && clr_st == 2'h2)
        else $error("clear did not zero counters");
    a_clear_idle: assert property (
        (ce && clr_st == 2'h2 && !clr_req && !logic_rst)
            |=> clr_st == 2'h0)
        else $error("clear state not back to idle");
    a_pulse_reset: assert property (
        (ce && wr_en && addr == 23'h7f && w == 16'had00 && !hold)
            |=> logic_rst && rcnt == 20'(RECOV_CYC))
        else $error("pulse code did not start recovery");
    a_recov_end: assert property (
        (ce && !hold && rcnt == 20'h1 && !wr_en) |=> !logic_rst)
        else $error("reset outlived recovery time");
    a_rst_defaults: assert property (
        (logic_rst && $past(logic_rst) && $past(ce))
            |-> unit == 5'h0 && !cut && mon_cfg == 16'h0)
        else $error("config not at defaults in reset");
endmodule // hpr_top

/* File: test/hpr_host.sv */
`timescale 1ns/1ps
// ****************************************
// Host processor driving the serial port
// ****************************************
module hpr_host
    import hpr_pkg::*;
(
    input wire logic clk_sys,
    output logic sclk,
    output logic cs_n,
    output logic sdin,
    input wire logic sdout
);
    // Idle: deselected, clock parked high
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdin = 1'b0;
    end

    // One word MSB first, 16 clk per bit (160 ns)
    task automatic word(input logic [15:0] w, output logic [15:0] r);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_sys);
            sclk <= 1'b0;
            sdin <= w[i];
            repeat (7) @(posedge clk_sys);
            @(negedge clk_sys);
            r[i] = sdout; // Settled long before the rise
            @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (7) @(posedge clk_sys);
        end
    endtask

    // Two command words, then one or two data words
    task automatic access(input hpr_cw_t c, input logic [15:0] lo,
        input int n, input logic [15:0] d0, input logic [15:0] d1,
        output logic [15:0] r0, output logic [15:0] r1);
        logic [15:0] x;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        word(c, x);
        word(lo, x);
        word(d0, r0);
        if (n > 1) word(d1, r1);
        repeat (8) @(posedge clk_sys);
        cs_n <= 1'b1;
        sdin <= ~sdin; // Released line must not keep its level
        repeat (64) @(posedge clk_sys);
    endtask
endmodule // hpr_host

/* File: test/host_port_reset_and_counter_ctl_bench.sv */
`timescale 1ns/1ps
`include "hpr_defs.svh"
// ****************************************
// Bench: serial accesses with expected values
// ****************************************
module host_port_reset_and_counter_ctl_bench;
    import hpr_pkg::*;
    localparam int unsigned RCY = 2000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic sclk, cs_n, sdin, sdout, logic_rst, cut;
    hpr_stat_t stat = '0;
    logic [15:0] mon_cfg, r0, r1;
    int num_errors = 0;
    int comparisons = 0;
    int n;

    always #5 clk_sys = ~clk_sys;

    hpr_top #(.RECOV_CYC(RCY)) hpr_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdin(sdin), .stat(stat),
        .sdout(sdout), .logic_rst(logic_rst), .cut(cut),
        .mon_cfg(mon_cfg));
    hpr_host hpr_host_i (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
        .sdin(sdin), .sdout(sdout));

    task automatic wrap_up;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One access; read words land in r0 and
    task automatic acc(input logic rd, input logic bc, input logic st,
        input logic [4:0] u, input logic [22:0] a, input int k,
        input logic [15:0] d0, input logic [15:0] d1);
        hpr_host_i.access(hpr_cw_t'{rd, bc, st, 1'b0, u, a[22:16]},
            a[15:0], k, d0, d1, r0, r1);
    endtask

    // Toggle the masked status bits k times, one change per 2 clk
    task automatic bump(input int k, input hpr_stat_t m);
        repeat (k) begin
            stat <= stat ^ m;
            repeat (2) @(posedge clk_sys);
        end
    endtask

    // Bounded wait for recovery to end, counting cycles
    task automatic wait_rec;
        n = 0;
        while (logic_rst === 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 3000) begin
            num_errors++;
            wrap_up;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(16'(cut), 16'h0000);
        chk(16'(logic_rst), 16'h0000);
        acc(1, 0, 0, 5'h00, `HPR_A_CFG, 1, 16'h0000, 16'h0000);
        chk(r0, 16'h0000);
        // Init word, then readback
        acc(0, 0, 0, 5'h00, `HPR_A_MON, 1, 16'h8006, 16'h0000);
        chk(mon_cfg, 16'h8006);
        acc(1, 0, 0, 5'h00, `HPR_A_MON, 1, 16'h0000, 16'h0000);
        chk(r0, 16'h8006);
        // Unit 5 with pass-through cut; unit 0 is then ignored
        acc(0, 0, 0, 5'h00, `HPR_A_CFG, 1, 16'h0025, 16'h0000);
        chk(16'(cut), 16'h0001);
        acc(0, 0, 0, 5'h00, `HPR_A_MON, 1, 16'h1234, 16'h0000);
        chk(mon_cfg, 16'h8006);
        acc(0, 0, 0, 5'h05, `HPR_A_MON, 1, 16'h1234, 16'h0000);
        chk(mon_cfg, 16'h1234);
        // Autostep from the unmapped word below
        acc(0, 0, 1, 5'h05, 23'h000056, 2, 16'hbeef, 16'h8006);
        chk(mon_cfg, 16'h8006);
        // Counters: 3 carrier, 2 rate, lock saturated
        bump(3, 5'b10000);
        bump(2, 5'b00010);
        bump(300, 5'b00001);
        acc(1, 0, 1, 5'h05, `HPR_A_CNT0, 2, 16'h0000, 16'h0000);
        chk(r0, 16'h0203);
        chk(r1, 16'h00ff);
        bump(1, 5'b00001);
        // This read doubles as the idle poll before the request
        acc(1, 0, 0, 5'h05, `HPR_A_CNT1, 1, 16'h0000, 16'h0000);
        chk(r0, 16'h00ff);
        // Four-way clear handshake, then counting resumes
        acc(0, 0, 0, 5'h05, `HPR_A_CNT1, 1, 16'h0100, 16'h0000);
        acc(1, 0, 1, 5'h05, `HPR_A_CNT0, 2, 16'h0000, 16'h0000);
        chk(r0, 16'h0000);
        chk(r1, 16'h0500);
        acc(0, 0, 0, 5'h05, `HPR_A_CNT1, 1, 16'h0000, 16'h0000);
        bump(1, 5'b00001);
        acc(1, 0, 0, 5'h05, `HPR_A_CNT1, 1, 16'h0000, 16'h0000);
        chk(r0, 16'h0001);
        // Held reset: only the reset word acts, unit back to 0
        acc(0, 0, 0, 5'h05, `HPR_A_SRST, 1, `HPR_C_HOLD, 16'h0000);
        chk(16'(logic_rst), 16'h0001);
        chk(16'(cut), 16'h0000);
        acc(1, 0, 0, 5'h00, `HPR_A_SRST, 1, 16'h0000, 16'h0000);
        chk(r0, `HPR_C_HOLD);
        acc(0, 0, 0, 5'h00, `HPR_A_MON, 1, 16'h8006, 16'h0000);
        chk(mon_cfg, 16'h0000);
        acc(0, 0, 0, 5'h00, `HPR_A_SRST, 1, `HPR_C_REL, 16'h0000);
        wait_rec;
        // About 75 of the recovery cycles pass inside the access
        chk(16'(n > 1900 && n < 1960), 16'h0001);
        acc(0, 0, 0, 5'h00, `HPR_A_MON, 1, 16'h8006, 16'h0000);
        // Broadcast pulse reaches a unit that does not match
        acc(0, 0, 0, 5'h00, `HPR_A_CFG, 1, 16'h0007, 16'h0000);
        acc(0, 1, 0, 5'h1a, `HPR_A_SRST, 1, `HPR_C_PULSE, 16'h0000);
        chk(16'(logic_rst), 16'h0001);
        wait_rec;
        chk(mon_cfg, 16'h0000);
        acc(1, 0, 0, 5'h00, `HPR_A_SRST, 1, 16'h0000, 16'h0000);
        chk(r0, 16'h0000);
        wrap_up;
    end
endmodule // host_port_reset_and_counter_ctl_bench
